// >>> rtl/loss_of_load_function.sv
// Top: three-phase loss-of-load (undercurrent) start and trip.
// Assumes phase magnitudes in 0.01 % of current-input rating, one per clock,
// and settings held stable by the surrounding configuration logic.
`timescale 1ns/1ps

module loss_of_load_function
  import loss_of_load_pkg::*;
#(
  parameter int CYC_PER_MS_P = loss_of_load_pkg::CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [loss_of_load_pkg::CUR_W-1:0] current_a,
  input wire logic [loss_of_load_pkg::CUR_W-1:0] current_b,
  input wire logic [loss_of_load_pkg::CUR_W-1:0] current_c,
  input wire logic function_enable_setting,
  input wire logic start_only_flag,
  input wire logic [loss_of_load_pkg::PCT_W-1:0] start_current_limit,
  input wire logic [loss_of_load_pkg::PCT_W-1:0] idle_current_limit,
  input wire logic [loss_of_load_pkg::PCT_W-1:0] object_to_input_rating_ratio,
  input wire logic [loss_of_load_pkg::DLY_W-1:0] trip_delay_time,
  input wire logic settings_load,
  output logic general_start,
  output logic general_trip,
  output logic phase_start_a,
  output logic phase_start_b,
  output logic phase_start_c
);
  import loss_of_load_pkg::*;

  // Threshold words carry two guard bits over the current word
  localparam int LIM_W = CUR_W + 2;
  // Cycle counter wide enough to count one millisecond
  localparam int CYC_W = $clog2(CYC_PER_MS_P + 1);

  // ==========================================================
  // Setting registers
  enable_t enable_r, enable_nxt;
  logic start_only_r, start_only_nxt;
  logic [PCT_W-1:0] start_lim_r, start_lim_nxt;
  logic [PCT_W-1:0] idle_lim_r, idle_lim_nxt;
  logic [PCT_W-1:0] ratio_r, ratio_nxt;
  logic [DLY_W-1:0] delay_r, delay_nxt;

  // Clamp a percentage setting into its legal range
  function automatic logic [PCT_W-1:0] clamp_pct(input logic [PCT_W-1:0] v,
                                                 input logic [PCT_W-1:0] lo,
                                                 input logic [PCT_W-1:0] hi);
    clamp_pct = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Scale a limit: limit% of ratio% of input rating, times reset factor/100,
  // giving units of 0.01 % of the input rating
  function automatic logic [LIM_W-1:0] scale_lim(input logic [PCT_W-1:0] lim,
                                                 input logic [PCT_W-1:0] ratio,
                                                 input logic [7:0] fac);
    logic [31:0] prod;
    prod = 32'(lim) * 32'(ratio) * 32'(fac) / 32'd100;
    scale_lim = LIM_W'(prod);
  endfunction

  // Latch settings on load strobe, clamped to range
  always_comb begin
    enable_nxt = enable_r;
    start_only_nxt = start_only_r;
    start_lim_nxt = start_lim_r;
    idle_lim_nxt = idle_lim_r;
    ratio_nxt = ratio_r;
    delay_nxt = delay_r;
    if (settings_load) begin
      enable_nxt = enable_t'(function_enable_setting);
      start_only_nxt = start_only_flag;
      start_lim_nxt = clamp_pct(start_current_limit, START_MIN, START_MAX);
      idle_lim_nxt = clamp_pct(idle_current_limit, IDLE_MIN, IDLE_MAX);
      ratio_nxt = clamp_pct(object_to_input_rating_ratio, RATIO_MIN, RATIO_MAX);
      delay_nxt = (trip_delay_time > DELAY_MAX) ? DELAY_MAX : trip_delay_time;
    end
  end

  // Setting registers with documented defaults
  always_ff @(posedge mclk) begin
    if (srst) begin
      enable_r <= ENABLE_DEF;
      start_only_r <= START_ONLY_DEF;
      start_lim_r <= START_DEF;
      idle_lim_r <= IDLE_DEF;
      ratio_r <= RATIO_DEF;
      delay_r <= DELAY_DEF;
    end else begin
      enable_r <= enable_nxt;
      start_only_r <= start_only_nxt;
      start_lim_r <= start_lim_nxt;
      idle_lim_r <= idle_lim_nxt;
      ratio_r <= ratio_nxt;
      delay_r <= delay_nxt;
    end
  end

  // ==========================================================
  // Scaled thresholds with pickup and release levels
  logic [LIM_W-1:0] up_pick_r, up_pick_nxt;
  logic [LIM_W-1:0] up_drop_r, up_drop_nxt;
  logic [LIM_W-1:0] lo_pick_r, lo_pick_nxt;
  logic [LIM_W-1:0] lo_drop_r, lo_drop_nxt;

  // Both band edges and their release levels from the latched settings
  always_comb begin
    up_pick_nxt = scale_lim(start_lim_r, ratio_r, 8'h64);
    up_drop_nxt = scale_lim(start_lim_r, ratio_r, 8'(UPPER_RESET_X100));
    lo_pick_nxt = scale_lim(idle_lim_r, ratio_r, 8'h64);
    lo_drop_nxt = scale_lim(idle_lim_r, ratio_r, 8'(LOWER_RESET_X100));
  end

  // Threshold registers: the triple product stays off the comparator path,
  // so a new setting reaches the detectors one clock after it is latched
  always_ff @(posedge mclk) begin
    if (srst) begin
      up_pick_r <= scale_lim(START_DEF, RATIO_DEF, 8'h64);
      up_drop_r <= scale_lim(START_DEF, RATIO_DEF, 8'(UPPER_RESET_X100));
      lo_pick_r <= scale_lim(IDLE_DEF, RATIO_DEF, 8'h64);
      lo_drop_r <= scale_lim(IDLE_DEF, RATIO_DEF, 8'(LOWER_RESET_X100));
    end else begin
      up_pick_r <= up_pick_nxt;
      up_drop_r <= up_drop_nxt;
      lo_pick_r <= lo_pick_nxt;
      lo_drop_r <= lo_drop_nxt;
    end
  end

  // ==========================================================
  // Per-phase detectors and timers
  logic [2:0] ph_start, ph_exp;
  logic [CUR_W-1:0] cur [3];
  logic active;

  // Phase currents gathered for the generate loop
  assign cur[0] = current_a;
  assign cur[1] = current_b;
  assign cur[2] = current_c;

  // The function is live only while the enable setting is On
  assign active = (enable_r == FUNC_ON);

  // One detector and timer per phase, sharing thresholds and trip delay
  for (genvar p = 0; p < 3; p++) begin : g_phase
    phase_undercurrent #(
      .CUR_W(CUR_W),
      .DLY_W(DLY_W),
      .CYC_W(CYC_W),
      .CYC_PER_MS(CYC_PER_MS_P)
    ) u_phase (
      .mclk(mclk),
      .srst(srst),
      .active(active),
      .phase_current(cur[p]),
      .upper_pick(up_pick_r),
      .upper_drop(up_drop_r),
      .lower_pick(lo_pick_r),
      .lower_drop(lo_drop_r),
      .delay_ms(delay_r),
      .phase_start(ph_start[p]),
      .phase_expired(ph_exp[p])
    );
  end

  // ==========================================================
  // Output stage
  logic gstart_r, gstart_nxt;
  logic gtrip_r, gtrip_nxt;
  logic [2:0] pstart_r, pstart_nxt;

  // General start and trip from all-phase agreement
  always_comb begin
    gstart_nxt = active && (&ph_start);
    gtrip_nxt = active && !start_only_r && (&ph_exp);
  end

  // General output registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      gstart_r <= 1'b0;
      gtrip_r <= 1'b0;
    end else begin
      gstart_r <= gstart_nxt;
      gtrip_r <= gtrip_nxt;
    end
  end

  // Per-phase start flags, forced low while the function is Off
  always_comb begin
    pstart_nxt = active ? ph_start : 3'h0;
  end

  // Per-phase output registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      pstart_r <= 3'h0;
    end else begin
      pstart_r <= pstart_nxt;
    end
  end

  // Top outputs straight from the registers above
  assign general_start = gstart_r;
  assign general_trip = gtrip_r;
  assign phase_start_a = pstart_r[0];
  assign phase_start_b = pstart_r[1];
  assign phase_start_c = pstart_r[2];
endmodule

// >>> rtl/loss_of_load_pkg.sv
// Package: settings, defaults and timing constants for the loss-of-load trip.
// Assumes a 10 MHz system clock and per-phase current magnitudes in
// units of 0.01 % of the current-input rating.
package loss_of_load_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ = 10000000;
  localparam int TICK_MS = 1; // Trip delay step in ms
  localparam int CYC_PER_MS = (CLK_HZ / 1000) * TICK_MS;

  // ==========================================================
  // Setting widths and ranges
  localparam int PCT_W = 8;
  localparam int DLY_W = 16;
  localparam int CUR_W = 16;
  localparam logic [PCT_W-1:0] START_MIN = 8'h14; // 20 %
  localparam logic [PCT_W-1:0] START_MAX = 8'h64; // 100 %
  localparam logic [PCT_W-1:0] START_DEF = 8'h28; // 40 %
  localparam logic [PCT_W-1:0] IDLE_MIN = 8'h01; // 1 %
  localparam logic [PCT_W-1:0] IDLE_MAX = 8'h14; // 20 %
  localparam logic [PCT_W-1:0] IDLE_DEF = 8'h0A; // 10 %
  localparam logic [PCT_W-1:0] RATIO_MIN = 8'h14; // 20 %
  localparam logic [PCT_W-1:0] RATIO_MAX = 8'h96; // 150 %
  localparam logic [PCT_W-1:0] RATIO_DEF = 8'h64; // 100 %
  localparam logic [DLY_W-1:0] DELAY_MAX = 16'hEA60; // 60000 ms
  localparam logic [DLY_W-1:0] DELAY_DEF = 16'h0064; // 100 ms

  // ==========================================================
  // Hysteresis in hundredths: release at 1.05 upper, 0.70 lower
  localparam int UPPER_RESET_X100 = 105;
  localparam int LOWER_RESET_X100 = 70;

  // Enable setting values
  typedef enum logic {
    FUNC_OFF = 1'b0,
    FUNC_ON = 1'b1
  } enable_t;
  localparam enable_t ENABLE_DEF = FUNC_OFF;
  localparam logic START_ONLY_DEF = 1'b0;
endpackage

// >>> rtl/phase_undercurrent.sv
// One phase: band detector with hysteresis and the phase delay timer.
// Assumes the limits arrive already scaled to the current-input units.
`timescale 1ns/1ps
module phase_undercurrent #(
  parameter int CUR_W = 16,
  parameter int DLY_W = 16,
  parameter int CYC_W = 14,
  parameter int CYC_PER_MS = 10000
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic active,
  input wire logic [CUR_W-1:0] phase_current,
  input wire logic [CUR_W+1:0] upper_pick,
  input wire logic [CUR_W+1:0] upper_drop,
  input wire logic [CUR_W+1:0] lower_pick,
  input wire logic [CUR_W+1:0] lower_drop,
  input wire logic [DLY_W-1:0] delay_ms,
  output logic phase_start,
  output logic phase_expired
);
  logic start_r, start_nxt;
  logic [CYC_W-1:0] cyc_r, cyc_nxt;
  logic [DLY_W-1:0] ms_r, ms_nxt;
  logic [CUR_W+1:0] cur;

  assign cur = {2'h0, phase_current};
  assign phase_start = start_r;
  assign phase_expired = start_r && (ms_r >= delay_ms);

  // Band detection with hysteresis, then ms counting while started
  always_comb begin
    start_nxt = start_r;
    cyc_nxt = cyc_r;
    ms_nxt = ms_r;
    if (!active) begin
      start_nxt = 1'b0;
    end else if (!start_r) begin
      start_nxt = (cur < upper_pick) && (cur > lower_pick);
    end else begin
      start_nxt = (cur < upper_drop) && (cur > lower_drop);
    end
    if (!start_r) begin
      cyc_nxt = '0;
      ms_nxt = '0;
    end else if (ms_r < delay_ms) begin
      if (cyc_r == CYC_W'(CYC_PER_MS - 1)) begin
        cyc_nxt = '0;
        ms_nxt = ms_r + 1'b1;
      end else begin
        cyc_nxt = cyc_r + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      start_r <= 1'b0;
      cyc_r <= '0;
      ms_r <= '0;
    end else begin
      start_r <= start_nxt;
      cyc_r <= cyc_nxt;
      ms_r <= ms_nxt;
    end
  end
endmodule

// >>> verification/current_source.sv
// Partner model: measurement stage handing three phase magnitudes.
// Assumes the bench sets the wanted levels between clock edges.
`timescale 1ns/1ps
module current_source (
  input wire logic mclk,
  input wire logic [15:0] set_a,
  input wire logic [15:0] set_b,
  input wire logic [15:0] set_c,
  output logic [15:0] cur_a,
  output logic [15:0] cur_b,
  output logic [15:0] cur_c
);
  // ==========================================================
  // Magnitudes change just after the edge, one new set per clock
  initial {cur_a, cur_b, cur_c} = '0;
  always @(posedge mclk) begin
    {cur_a, cur_b, cur_c} <= #1 {set_a, set_b, set_c};
  end
endmodule

// >>> verification/loss_of_load_monitor.sv
// Checker: start and trip relations seen at the top ports.
// Assumes currents in 0.01 % of the input rating.
`timescale 1ns/1ps
module loss_of_load_monitor (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [15:0] current_a,
  input wire logic settings_load,
  input wire logic [15:0] trip_delay_time,
  input wire logic general_start,
  input wire logic general_trip,
  input wire logic phase_start_a,
  input wire logic phase_start_b,
  input wire logic phase_start_c
);
  // ==========================================================
  // Helper: a zero trip delay lets trip rise together with start
  logic zero_dly_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      zero_dly_r <= 1'b0;
    end else if (settings_load) begin
      zero_dly_r <= (trip_delay_time == 16'h0000);
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_start_all_phases:
    assert property (general_start |-> phase_start_a && phase_start_b && phase_start_c)
    else $error("general start without all phases");
  a_rise_in_band:
    assert property ($rose(phase_start_a) |-> $past(current_a) > 16'h0000
      && $past(current_a) < 16'h3A98) else $error("phase start outside band");
  a_zero_drop:
    assert property (current_a == 16'h0000 |-> ##2 !phase_start_a)
    else $error("phase start held at zero current");
  a_high_drop:
    assert property (current_a > 16'h3E00 |-> ##2 !phase_start_a)
    else $error("phase start held above upper release");
  a_trip_needs_start:
    assert property (general_trip |-> general_start) else $error("trip without start");
  a_trip_after_start:
    assert property ($rose(general_trip) && !zero_dly_r |-> $past(general_start))
    else $error("trip rose without prior start");
  a_no_instant_trip:
    assert property ($rose(general_start) && !zero_dly_r |-> !general_trip)
    else $error("trip with start");
  a_reset_quiet:
    assert property ($past(srst) |-> !general_start && !general_trip && !phase_start_a)
    else $error("output set after reset");
endmodule
bind loss_of_load_function loss_of_load_monitor loss_of_load_monitor_i (.mclk(mclk),
  .srst(srst), .current_a(current_a), .settings_load(settings_load),
  .trip_delay_time(trip_delay_time), .general_start(general_start),
  .general_trip(general_trip), .phase_start_a(phase_start_a),
  .phase_start_b(phase_start_b), .phase_start_c(phase_start_c));

// >>> verification/loss_of_load_function_tb.sv
// Testbench: scripted start and trip scenarios for the loss-of-load block.
// Assumes the source model and checker are compiled first.
`timescale 1ns/1ps
module loss_of_load_function_tb;
  logic mclk, srst, en, so, ld, gs, gt, pa, pb, pc;
  logic [15:0] sa, sb, sc, ca, cb, cc, dl;
  logic [7:0] st, id, ra;
  int n_errors, check_count, n;
  // ==========================================================
  // Clock, source and design
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  current_source current_source_i (.mclk(mclk), .set_a(sa), .set_b(sb), .set_c(sc),
    .cur_a(ca), .cur_b(cb), .cur_c(cc));
  loss_of_load_function #(.CYC_PER_MS_P(4)) loss_of_load_function_i (.mclk(mclk),
    .srst(srst), .current_a(ca), .current_b(cb), .current_c(cc),
    .function_enable_setting(en), .start_only_flag(so), .start_current_limit(st),
    .idle_current_limit(id), .object_to_input_rating_ratio(ra), .trip_delay_time(dl),
    .settings_load(ld), .general_start(gs), .general_trip(gt), .phase_start_a(pa),
    .phase_start_b(pb), .phase_start_c(pc));
  // Tasks: compare, wait, drive
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wait_for(input logic trip, output int k);
    k = 0;
    while ((trip ? gt : gs) !== 1'b1) begin
      tick(1);
      k++;
      if (k > 400) begin
        n_errors++;
        end_of_test();
      end
    end
  endtask
  task automatic cur(input logic [15:0] a, b, c);
    {sa, sb, sc} = {a, b, c};
    tick(5);
  endtask
  task automatic load(input logic e, s, input logic [7:0] t, i, r, input logic [15:0] d);
    {en, so, st, id, ra, dl, ld} = {e, s, t, i, r, d, 1'b1};
    tick(1);
    ld = 0;
  endtask
  // Main sequence
  initial begin
    {n_errors, check_count, srst, ld, sa, sb, sc} = {32'h0, 32'h0, 1'b1, 1'b0, 48'h0};
    {en, so, st, id, ra, dl} = {2'b10, 8'h28, 8'h0A, 8'h64, 16'h0003};
    tick(5);
    srst = 0;
    cur(16'h07D0, 16'h07D0, 16'h07D0);
    chk("default_off", 0, gs);
    load(1, 0, 8'h28, 8'h0A, 8'h64, 16'h0003);
    wait_for(0, n);
    chk("phases", 16'h0007, {pa, pb, pc});
    wait_for(1, n);
    chk("trip_delay", 16'h000C, n[15:0]);
    cur(16'h1004, 16'h1004, 16'h1004);
    chk("upper_hold", 1, gs);
    cur(16'h10CC, 16'h10CC, 16'h10CC);
    chk("upper_drop", 0, {gs, gt});
    cur(16'h07D0, 16'h07D0, 16'h07D0);
    cur(16'h0320, 16'h0320, 16'h0320);
    chk("lower_hold", 1, gs);
    cur(16'h0258, 16'h0258, 16'h0258);
    chk("lower_drop", 0, gs);
    cur(16'h07D0, 16'h01F4, 16'h07D0);
    tick(20);
    chk("one_low", 16'h0014, {pa, pb, pc, gs, gt});
    load(1, 1, 8'h28, 8'h0A, 8'h64, 16'h0003);
    cur(16'h07D0, 16'h07D0, 16'h07D0);
    tick(20);
    chk("start_only", 16'h0002, {gs, gt});
    load(1, 0, 8'h28, 8'h0A, 8'h32, 16'h0003);
    cur(16'h0834, 16'h0834, 16'h0834);
    chk("ratio_high", 0, gs);
    cur(16'h01F5, 16'h01F5, 16'h01F5);
    chk("ratio_band", 1, gs);
    load(1, 0, 8'hC8, 8'h0A, 8'h64, 16'h0000);
    cur(16'h0000, 16'h0000, 16'h0000);
    {sa, sb, sc} = {3{16'h2328}};
    wait_for(0, n);
    wait_for(1, n);
    chk("clamp_zero_delay", 0, n[15:0]);
    cur(16'h4000, 16'h4000, 16'h4000);
    chk("above_max", 0, gs);
    load(1, 0, 8'h28, 8'h0A, 8'hFF, 16'h0003);
    cur(16'h07D0, 16'h07D0, 16'h07D0);
    chk("ratio_clamp", 1, gs);
    load(1, 0, 8'h28, 8'h00, 8'h64, 16'h0003);
    cur(16'h0032, 16'h0032, 16'h0032);
    chk("idle_clamp", 0, gs);
    load(0, 0, 8'h28, 8'h0A, 8'h64, 16'h0003);
    cur(16'h07D0, 16'h07D0, 16'h07D0);
    chk("set_off", 0, {gs, gt, pa});
    load(1, 0, 8'h28, 8'h0A, 8'h64, 16'h0003);
    wait_for(0, n);
    srst = 1;
    tick(2);
    srst = 0;
    tick(8);
    chk("reset_off", 0, {gs, gt, pa});
    end_of_test();
  end
endmodule
